// ==== core/mcod_defines.svh ====
// Offsets, opcodes, field positions and reset values of the operand decoder
`ifndef MCOD_DEFINES_SVH
`define MCOD_DEFINES_SVH

// Register byte offsets on the AXI4-Lite bus
`define MCOD_OFF_INSTR  8'h00
`define MCOD_OFF_PROBE  8'h04
`define MCOD_OFF_PDATA  8'h08
`define MCOD_OFF_FLAGS  8'h0C
`define MCOD_OFF_CTRL   8'h10
`define MCOD_OFF_STATE  8'h14
`define MCOD_OFF_DIAG   8'h18
`define MCOD_OFF_JUMP   8'h1C
`define MCOD_OFF_JR1    8'h20
`define MCOD_OFF_JR2    8'h24
`define MCOD_OFF_SPARE  8'h28

// Opcodes in instruction bits 15..10
`define MCOD_OP_ADD     6'h0A
`define MCOD_OP_ADDI    6'h0C
`define MCOD_OP_SUBI    6'h06
`define MCOD_OP_MUL     6'h0D
`define MCOD_OP_LDIRH   6'h10
`define MCOD_OP_LDIRL   6'h11
`define MCOD_OP_BYTE_LEFT_SHIFT_INSTRUCTION    6'h12
`define MCOD_OP_BYTE_RIGHT_SHIFT_INSTRUCTION    6'h13
`define MCOD_OP_RSTREG  6'h14

// Math flags word bit positions
`define MCOD_FLG_C      0
`define MCOD_FLG_RZ     1
`define MCOD_FLG_RS     2
`define MCOD_FLG_UU     3
`define MCOD_FLG_UO     4
`define MCOD_FLG_SU     5
`define MCOD_FLG_SO     6

// Diagnostics word bit positions
`define MCOD_DIAG_ILL   0
`define MCOD_DIAG_REF   1

// ALU register indices
`define MCOD_IDX_IR     3'h5
`define MCOD_IDX_MH     3'h6
`define MCOD_IDX_ML     3'h7
`define MCOD_RS_MAX     3'h5

// Reset values and bus answers
`define MCOD_RST_WORD   16'h0000
`define MCOD_RESP_OKAY  2'h0
`define MCOD_RESP_SLV   2'h2

`endif

// ==== core/mcod_pkg.sv ====
// Types shared by the operand decoder modules
package mcod_pkg;

  // Target class of a core register field code
  typedef enum logic [3:0] {
    core_alu, core_math_flags, core_spare, core_jump_one, core_jump_two,
    core_counter, core_limit, core_flag, core_control, core_state,
    core_serial_data, core_setpoint, core_serial_addr, core_irq_flags,
    core_exchange
  } mcod_core_id_t;

  // Class plus index within the class
  typedef struct packed {
    mcod_core_id_t id;
    logic [2:0]    sub;
  } mcod_core_sel_t;

  // Result of decoding all operand fields
  typedef struct packed {
    logic [2:0]     alu_idx;
    logic           rs_ok;
    mcod_core_sel_t core;
    logic           jump_two;
  } mcod_decode_t;

endpackage

// ==== core/mcod_field_decode.sv ====
// Operand field decoder: ALU, restricted, core register and jump fields
`include "mcod_defines.svh"

module mcod_field_decode (
  input  wire logic [2:0]           alu_operand_field_i,
  input  wire logic [2:0]           restricted_operand_field_i,
  input  wire logic [4:0]           core_register_field_i,
  input  wire logic                 jump_select_field_i,
  output mcod_pkg::mcod_decode_t    decode_o
);

  logic [4:0] code;

  assign code = core_register_field_i;

  // All fields in one process, so the output struct has one driver
  always_comb begin
    decode_o.alu_idx  = alu_operand_field_i;
    decode_o.rs_ok    = (restricted_operand_field_i <= `MCOD_RS_MAX);
    decode_o.jump_two = jump_select_field_i;
    decode_o.core.id  = mcod_pkg::core_alu;
    decode_o.core.sub = code[2:0];
    unique case (code[4:3])
      2'b00: begin
        decode_o.core.id = mcod_pkg::core_alu;
      end
      2'b01: begin
        decode_o.core.sub = {1'b0, code[1:0]};
        if (code[2]) begin
          decode_o.core.id = mcod_pkg::core_counter;
        end else begin
          unique case (code[1:0])
            2'b00: decode_o.core.id = mcod_pkg::core_math_flags;
            2'b01: decode_o.core.id = mcod_pkg::core_spare;
            2'b10: decode_o.core.id = mcod_pkg::core_jump_one;
            2'b11: decode_o.core.id = mcod_pkg::core_jump_two;
          endcase
        end
      end
      2'b10: begin
        decode_o.core.sub = {1'b0, code[1:0]};
        if (!code[2]) begin
          decode_o.core.id = mcod_pkg::core_limit;
        end else begin
          unique case (code[1:0])
            2'b00: decode_o.core.id = mcod_pkg::core_flag;
            2'b01: decode_o.core.id = mcod_pkg::core_control;
            2'b10: decode_o.core.id = mcod_pkg::core_state;
            2'b11: decode_o.core.id = mcod_pkg::core_serial_data;
          endcase
        end
      end
      2'b11: begin
        unique case (code[2:0])
          3'h5:    decode_o.core.id = mcod_pkg::core_serial_addr;
          3'h6:    decode_o.core.id = mcod_pkg::core_irq_flags;
          3'h7:    decode_o.core.id = mcod_pkg::core_exchange;
          default: decode_o.core.id = mcod_pkg::core_setpoint;
        endcase
      end
    endcase
  end

endmodule

// ==== core/mcod_top.sv ====
// Microcore operand decoder and adder datapath behind an AXI4-Lite slave
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`include "mcod_defines.svh"

module mcod_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic                   clk_i,
  input  wire logic                   reset_n_i,
  input  wire logic [ADDR_W-1:0]      s_axi_awaddr_i,
  input  wire logic [2:0]             s_axi_awprot_i,
  input  wire logic                   s_axi_awvalid_i,
  output logic                        s_axi_awready_o,
  input  wire logic [31:0]            s_axi_wdata_i,
  input  wire logic [3:0]             s_axi_wstrb_i,
  input  wire logic                   s_axi_wvalid_i,
  output logic                        s_axi_wready_o,
  output logic [1:0]                  s_axi_bresp_o,
  output logic                        s_axi_bvalid_o,
  input  wire logic                   s_axi_bready_i,
  input  wire logic [ADDR_W-1:0]      s_axi_araddr_i,
  input  wire logic [2:0]             s_axi_arprot_i,
  input  wire logic                   s_axi_arvalid_i,
  output logic                        s_axi_arready_o,
  output logic [31:0]                 s_axi_rdata_o,
  output logic [1:0]                  s_axi_rresp_o,
  output logic                        s_axi_rvalid_o,
  input  wire logic                   s_axi_rready_i,
  input  wire logic [15:0]            ext_data_i,
  output mcod_pkg::mcod_core_sel_t    ext_sel_o,
  output logic [15:0]                 jump_target_o
);

  // Architectural state
  logic [15:0]             alu_reg [8];
  logic [15:0]             math_flags_word;
  logic [15:0]             spare_word;
  logic [15:0]             control_word;
  logic [15:0]             state_bits_word;
  logic [15:0]             diag_word;
  logic [15:0]             jump_target_one;
  logic [15:0]             jump_target_two;
  logic [15:0]             last_instr;
  logic [4:0]              probe_code;
  logic                    probe_jump;

  // Bus slave state
  logic                    aw_held;
  logic                    w_held;
  logic [ADDR_W-1:0]       aw_addr;
  logic [31:0]             w_data;
  logic [3:0]              w_strb;
  logic                    next_aw_held;
  logic                    next_w_held;
  logic                    next_rvalid;
  logic                    aw_take;
  logic                    w_take;
  logic                    ar_take;
  logic                    wr_do;

  // Decoder results and datapath nets
  mcod_pkg::mcod_decode_t  dec;
  mcod_pkg::mcod_decode_t  res_dec;
  logic [15:0]             instr;
  logic [5:0]              opc;
  logic                    exec;
  logic [15:0]             op1v;
  logic [15:0]             op2v;
  logic [15:0]             irv;
  logic [15:0]             add_b;
  logic [16:0]             sum17;
  logic [16:0]             diff17;
  logic [31:0]             prod;
  logic [15:0]             add_flags;
  logic [15:0]             sub_flags;
  logic [15:0]             core_val;

  // Instruction effects
  logic                    wr_en;
  logic [2:0]              wr_idx;
  logic [15:0]             wr_val;
  logic                    flag_en;
  logic [15:0]             flag_val;
  logic                    mul_en;
  logic                    rst_en;
  logic                    bad;
  logic                    refuse;

  // Write address hits
  logic                    wh_instr;
  logic                    wh_probe;
  logic                    wh_ctrl;
  logic                    wh_state;
  logic                    wh_diag;
  logic                    wh_jr1;
  logic                    wh_jr2;
  logic                    wh_spare;
  logic                    wh_any;

  // Read address hits
  logic                    rh_instr;
  logic                    rh_probe;
  logic                    rh_pdata;
  logic                    rh_flags;
  logic                    rh_ctrl;
  logic                    rh_state;
  logic                    rh_diag;
  logic                    rh_jump;
  logic                    rh_jr1;
  logic                    rh_jr2;
  logic                    rh_spare;
  logic                    rh_any;
  logic [31:0]             rd_word;

  // Byte-lane merge into a 16-bit register; upper lanes ignored
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // Handshakes; a write completes once address and data are both held
  assign aw_take      = s_axi_awvalid_i & s_axi_awready_o;
  assign w_take       = s_axi_wvalid_i & s_axi_wready_o;
  assign ar_take      = s_axi_arvalid_i & s_axi_arready_o;
  assign wr_do        = aw_held & w_held & ~s_axi_bvalid_o;
  assign next_aw_held = wr_do ? 1'b0 : (aw_held | aw_take);
  assign next_w_held  = wr_do ? 1'b0 : (w_held | w_take);
  assign next_rvalid  = ar_take | (s_axi_rvalid_o & ~s_axi_rready_i);

  // Write decode on the held address
  assign wh_instr = (aw_addr == `MCOD_OFF_INSTR);
  assign wh_probe = (aw_addr == `MCOD_OFF_PROBE);
  assign wh_ctrl  = (aw_addr == `MCOD_OFF_CTRL);
  assign wh_state = (aw_addr == `MCOD_OFF_STATE);
  assign wh_diag  = (aw_addr == `MCOD_OFF_DIAG);
  assign wh_jr1   = (aw_addr == `MCOD_OFF_JR1);
  assign wh_jr2   = (aw_addr == `MCOD_OFF_JR2);
  assign wh_spare = (aw_addr == `MCOD_OFF_SPARE);
  assign wh_any   = wh_instr | wh_probe | wh_ctrl | wh_state | wh_diag |
                    wh_jr1 | wh_jr2 | wh_spare;

  // An instruction runs only when both low byte lanes are written
  assign exec  = wr_do & wh_instr & (w_strb[1:0] == 2'b11);
  assign instr = w_data[15:0];
  assign opc   = instr[15:10];

  // Source operands straight from the ALU field codes
  assign op1v  = alu_reg[instr[2:0]];
  assign op2v  = alu_reg[instr[5:3]];
  assign irv   = alu_reg[`MCOD_IDX_IR];

  // One adder serves both addition forms
  assign add_b  = (opc == `MCOD_OP_ADDI) ? irv : op2v;
  assign sum17  = {1'b0, op1v} + {1'b0, add_b};
  assign diff17 = {1'b0, op1v} - {1'b0, irv};
  assign prod   = op1v * op2v;

  // Addition flags: no unsigned underflow possible on a sum
  assign add_flags = {9'h000,
                      ~op1v[15] & ~add_b[15] & sum17[15],
                      op1v[15] & add_b[15] & ~sum17[15],
                      sum17[16],
                      1'b0,
                      sum17[15],
                      sum17[15:0] == 16'h0000,
                      sum17[16]};

  // Subtraction flags: carry carries the borrow
  assign sub_flags = {9'h000,
                      ~op1v[15] & irv[15] & diff17[15],
                      op1v[15] & ~irv[15] & ~diff17[15],
                      1'b0,
                      diff17[16],
                      diff17[15],
                      diff17[15:0] == 16'h0000,
                      diff17[16]};

  // Decoder: result field of the instruction, core and jump probe
  mcod_field_decode u_res_dec (
    .alu_operand_field_i        (instr[9:7]),
    .restricted_operand_field_i (instr[9:7]),
    .core_register_field_i      (probe_code),
    .jump_select_field_i        (probe_jump),
    .decode_o                   (res_dec)
  );
  assign dec = res_dec;

  // Instruction execute: effects for the cycle of the write
  always_comb begin
    wr_en    = 1'b0;
    wr_idx   = dec.alu_idx;
    wr_val   = 16'h0000;
    flag_en  = 1'b0;
    flag_val = math_flags_word;
    mul_en   = 1'b0;
    rst_en   = 1'b0;
    bad      = 1'b0;
    refuse   = 1'b0;
    if (exec) begin
      unique case (opc)
        `MCOD_OP_ADD: begin
          if (instr[6]) begin
            bad = 1'b1;
          end else begin
            wr_en    = 1'b1;
            wr_val   = sum17[15:0];
            flag_en  = 1'b1;
            flag_val = add_flags;
          end
        end
        `MCOD_OP_ADDI: begin
          wr_en    = 1'b1;
          wr_val   = sum17[15:0];
          flag_en  = 1'b1;
          flag_val = add_flags;
        end
        `MCOD_OP_SUBI: begin
          if (!dec.rs_ok) begin
            refuse = 1'b1;
          end else begin
            wr_en    = 1'b1;
            wr_val   = diff17[15:0];
            flag_en  = 1'b1;
            flag_val = sub_flags;
          end
        end
        `MCOD_OP_MUL: begin
          mul_en = 1'b1;
        end
        `MCOD_OP_LDIRH: begin
          wr_en  = 1'b1;
          wr_idx = `MCOD_IDX_IR;
          wr_val = {instr[7:0], instr[8] ? 8'h00 : irv[7:0]};
        end
        `MCOD_OP_LDIRL: begin
          wr_en  = 1'b1;
          wr_idx = `MCOD_IDX_IR;
          wr_val = {instr[8] ? 8'h00 : irv[15:8], instr[7:0]};
        end
        `MCOD_OP_BYTE_LEFT_SHIFT_INSTRUCTION: begin
          wr_en  = 1'b1;
          wr_idx = instr[2:0];
          wr_val = {op1v[7:0], 8'h00};
        end
        `MCOD_OP_BYTE_RIGHT_SHIFT_INSTRUCTION: begin
          wr_en  = 1'b1;
          wr_idx = instr[2:0];
          wr_val = {8'h00, op1v[15:8]};
        end
        `MCOD_OP_RSTREG: begin
          rst_en = 1'b1;
        end
        default: begin
          bad = 1'b1;
        end
      endcase
    end
  end

  // Core field value; external classes come from ext_data_i, the rest from local registers
  always_comb begin
    unique case (dec.core.id)
      mcod_pkg::core_alu:        core_val = alu_reg[dec.core.sub];
      mcod_pkg::core_math_flags: core_val = math_flags_word;
      mcod_pkg::core_spare:      core_val = spare_word;
      mcod_pkg::core_jump_one:   core_val = jump_target_one;
      mcod_pkg::core_jump_two:   core_val = jump_target_two;
      mcod_pkg::core_control:    core_val = control_word;
      mcod_pkg::core_state:      core_val = state_bits_word;
      default:                   core_val = ext_data_i;
    endcase
  end

  // Read decode
  assign rh_instr = (s_axi_araddr_i == `MCOD_OFF_INSTR);
  assign rh_probe = (s_axi_araddr_i == `MCOD_OFF_PROBE);
  assign rh_pdata = (s_axi_araddr_i == `MCOD_OFF_PDATA);
  assign rh_flags = (s_axi_araddr_i == `MCOD_OFF_FLAGS);
  assign rh_ctrl  = (s_axi_araddr_i == `MCOD_OFF_CTRL);
  assign rh_state = (s_axi_araddr_i == `MCOD_OFF_STATE);
  assign rh_diag  = (s_axi_araddr_i == `MCOD_OFF_DIAG);
  assign rh_jump  = (s_axi_araddr_i == `MCOD_OFF_JUMP);
  assign rh_jr1   = (s_axi_araddr_i == `MCOD_OFF_JR1);
  assign rh_jr2   = (s_axi_araddr_i == `MCOD_OFF_JR2);
  assign rh_spare = (s_axi_araddr_i == `MCOD_OFF_SPARE);
  assign rh_any   = rh_instr | rh_probe | rh_pdata | rh_flags | rh_ctrl |
                    rh_state | rh_diag | rh_jump | rh_jr1 | rh_jr2 | rh_spare;

  // Read data mux; upper half reads as zero
  assign rd_word = {16'h0000,
                    ({16{rh_instr}} & last_instr) |
                    ({16{rh_probe}} & {7'h00, probe_jump, 3'h0, probe_code}) |
                    ({16{rh_pdata}} & core_val) |
                    ({16{rh_flags}} & math_flags_word) |
                    ({16{rh_ctrl}}  & control_word) |
                    ({16{rh_state}} & state_bits_word) |
                    ({16{rh_diag}}  & diag_word) |
                    ({16{rh_jump}}  & jump_target_o) |
                    ({16{rh_jr1}}   & jump_target_one) |
                    ({16{rh_jr2}}   & jump_target_two) |
                    ({16{rh_spare}} & spare_word)};

  // Write channel handshake and response
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_held         <= 1'b0;
      w_held          <= 1'b0;
      aw_addr         <= '0;
      w_data          <= 32'h0000_0000;
      w_strb          <= 4'h0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= `MCOD_RESP_OKAY;
    end else begin
      aw_held         <= next_aw_held;
      w_held          <= next_w_held;
      s_axi_awready_o <= ~next_aw_held;
      s_axi_wready_o  <= ~next_w_held;
      if (aw_take) begin
        aw_addr <= s_axi_awaddr_i;
      end
      if (w_take) begin
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end
      if (wr_do) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wh_any ? `MCOD_RESP_OKAY : `MCOD_RESP_SLV;
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // Read channel: one read in flight, data captured at the address
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= `MCOD_RESP_OKAY;
    end else begin
      s_axi_rvalid_o  <= next_rvalid;
      s_axi_arready_o <= ~next_rvalid;
      if (ar_take) begin
        s_axi_rdata_o <= rd_word;
        s_axi_rresp_o <= rh_any ? `MCOD_RESP_OKAY : `MCOD_RESP_SLV;
      end
    end
  end

  // ALU register file; product lands in the upper/lower pair
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < 8; i++) begin
        alu_reg[i] <= `MCOD_RST_WORD;
      end
    end else if (mul_en) begin
      alu_reg[`MCOD_IDX_MH] <= prod[31:16];
      alu_reg[`MCOD_IDX_ML] <= prod[15:0];
    end else if (wr_en) begin
      alu_reg[wr_idx] <= wr_val;
    end
  end

  // Flags move with the result write, never a cycle later
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      math_flags_word <= `MCOD_RST_WORD;
    end else if (flag_en) begin
      math_flags_word <= flag_val;
    end
  end

  // Side words; register reset wins over a bus write only by exclusion
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      control_word    <= `MCOD_RST_WORD;
      state_bits_word <= `MCOD_RST_WORD;
      spare_word      <= `MCOD_RST_WORD;
      jump_target_one <= `MCOD_RST_WORD;
      jump_target_two <= `MCOD_RST_WORD;
      last_instr      <= `MCOD_RST_WORD;
      probe_code      <= 5'h00;
      probe_jump      <= 1'b0;
    end else begin
      if (rst_en) begin
        control_word    <= `MCOD_RST_WORD;
        state_bits_word <= `MCOD_RST_WORD;
      end
      if (wr_do && wh_ctrl) control_word <= merge16(control_word, w_data, w_strb);
      if (wr_do && wh_state) state_bits_word <= merge16(state_bits_word, w_data, w_strb);
      if (wr_do && wh_spare) spare_word <= merge16(spare_word, w_data, w_strb);
      if (wr_do && wh_jr1) jump_target_one <= merge16(jump_target_one, w_data, w_strb);
      if (wr_do && wh_jr2) jump_target_two <= merge16(jump_target_two, w_data, w_strb);
      if (exec) last_instr <= instr;
      if (wr_do && wh_probe && w_strb[0]) probe_code <= w_data[4:0];
      if (wr_do && wh_probe && w_strb[1]) probe_jump <= w_data[8];
    end
  end

  // Sticky diagnostics: a new event beats a software or reset clear
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      diag_word <= `MCOD_RST_WORD;
    end else begin
      if (rst_en) diag_word <= `MCOD_RST_WORD;
      else if (wr_do && wh_diag) diag_word <= diag_word & ~w_data[15:0];
      if (bad) diag_word[`MCOD_DIAG_ILL] <= 1'b1;
      if (refuse) diag_word[`MCOD_DIAG_REF] <= 1'b1;
    end
  end

  // Registered side outputs: selected class and selected jump target
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_sel_o     <= '0;
      jump_target_o <= `MCOD_RST_WORD;
    end else begin
      ext_sel_o     <= dec.core;
      jump_target_o <= dec.jump_two ? jump_target_two : jump_target_one;
    end
  end

endmodule

// ==== tb/mcod_ext_model.sv ====
// Far-side register model answering the selected external register
module mcod_ext_model (
  input  wire mcod_pkg::mcod_core_sel_t sel_i,
  output logic [15:0]                   data_o
);
  // Only indexed classes show their index, the rest read index zero
  wire logic idx = sel_i.id inside {mcod_pkg::core_counter, mcod_pkg::core_limit,
                                    mcod_pkg::core_setpoint};
  assign data_o = {8'h5A, sel_i.id, 1'b0, idx ? sel_i.sub : 3'h0};
endmodule

// ==== tb/mcod_checker.sv ====
// Handshake and selection assertions on the decoder top ports
module mcod_checker (
  input wire logic                    clk_i,
  input wire logic                    reset_n_i,
  input wire logic                    s_axi_awvalid_i,
  input wire logic                    s_axi_awready_o,
  input wire logic                    s_axi_wvalid_i,
  input wire logic                    s_axi_wready_o,
  input wire logic [1:0]              s_axi_bresp_o,
  input wire logic                    s_axi_bvalid_o,
  input wire logic                    s_axi_bready_i,
  input wire logic                    s_axi_arvalid_i,
  input wire logic                    s_axi_arready_o,
  input wire logic [31:0]             s_axi_rdata_o,
  input wire logic                    s_axi_rvalid_o,
  input wire logic                    s_axi_rready_i,
  input wire mcod_pkg::mcod_core_sel_t ext_sel_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Handshake steps
  sequence s_ar; s_axi_arvalid_i && s_axi_arready_o; endsequence
  sequence s_wr; s_axi_awvalid_i && s_axi_awready_o &&
    s_axi_wvalid_i && s_axi_wready_o; endsequence
  property p_b_hold; s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold; s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_r_ans; s_ar |=> s_axi_rvalid_o; endproperty
  a_r_ans: assert property (p_r_ans) else $error("read answer late");
  property p_b_ans; s_wr |-> ##2 s_axi_bvalid_o; endproperty
  a_b_ans: assert property (p_b_ans) else $error("write answer late");
  property p_ar_blk; s_axi_rvalid_o |-> !s_axi_arready_o; endproperty
  a_ar_blk: assert property (p_ar_blk) else $error("read taken while busy");
  property p_w_blk; s_wr |=> !s_axi_awready_o && !s_axi_wready_o; endproperty
  a_w_blk: assert property (p_w_blk) else $error("write taken while busy");
  property p_cnt; ext_sel_o.id inside {mcod_pkg::core_counter, mcod_pkg::core_limit} |->
    ext_sel_o.sub < 3'h4; endproperty
  a_cnt: assert property (p_cnt) else $error("counter index out of range");
  property p_set; ext_sel_o.id == mcod_pkg::core_setpoint |-> ext_sel_o.sub < 3'h5; endproperty
  a_set: assert property (p_set) else $error("set-point index out of range");
endmodule

// ==== tb/mcod_top_tb.sv ====
// Self-checking bench of the operand decoder over its register bus
module mcod_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 0, reset_n_i = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [1:0]  bresp, rresp, bq[$];
  logic [33:0] rq[$];
  logic [15:0] ext_data, jump, lfsr = 16'h001C, j1, j2;
  int          error_cnt = 0, cmp_count = 0, cyc = 0;
  mcod_pkg::mcod_core_sel_t sel;
  // Clock of 40 ns
  always #20 clk_i = ~clk_i;
  mcod_top dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awprot_i(3'h0), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arprot_i(3'h0),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .ext_data_i(ext_data), .ext_sel_o(sel), .jump_target_o(jump));
  mcod_ext_model ext (.sel_i(sel), .data_o(ext_data));
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One transfer; ready is raised a cycle late so answers must stand
  task automatic bus(input logic w, input logic [7:0] a, input logic [33:0] e);
    logic ta, tw, tb, tv;
    if (w) begin
      bq.push_back(e[33:32]);
      awaddr <= a;
      wdata <= e[31:0];
      awvalid <= 1;
      wvalid <= 1;
    end else begin
      rq.push_back(e);
      araddr <= a;
      arvalid <= 1;
    end
    do begin
      @(negedge clk_i);
      ta = (awvalid & awready) | (arvalid & arready);
      tw = wvalid & wready;
      tb = (bready & bvalid) | (rready & rvalid);
      tv = bvalid | rvalid;
      @(posedge clk_i);
      if (ta) {awvalid, arvalid} <= 2'b00;
      if (tw) wvalid <= 0;
      if (tb) {bready, rready} <= 2'b00;
      else if (tv) {bready, rready} <= {w, ~w};
    end while (!tb);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1, a, {18'h0_0000, d});
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] d);
    bus(0, a, {18'h0_0000, d});
  endtask
  // Select a core code, let the selection settle, read the picked value
  task automatic pr(input logic [8:0] c, input logic [15:0] d);
    wr(8'h04, {7'h00, c});
    @(posedge clk_i);
    rd(8'h08, d);
  endtask
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  // Expected far-side answer for an external core code
  function automatic logic [15:0] xv(input logic [4:0] c);
    mcod_pkg::mcod_core_id_t id;
    id = c < 16 ? mcod_pkg::core_counter : c < 20 ? mcod_pkg::core_limit : mcod_pkg::core_setpoint;
    if (c == 20) id = mcod_pkg::core_flag;
    if (c == 23) id = mcod_pkg::core_serial_data;
    if (c > 28) id = c == 29 ? mcod_pkg::core_serial_addr : c == 30 ? mcod_pkg::core_irq_flags
                             : mcod_pkg::core_exchange;
    return {8'h5A, id, 1'b0, c > 23 && c < 29 ? c[2:0] : c < 20 ? {1'b0, c[1:0]} : 3'h0};
  endfunction
  // Answer checker and hang guard
  always @(posedge clk_i) begin
    if (bvalid & bready) chk(bresp === bq.pop_front(), "write response");
    if (rvalid & rready) chk({rresp, rdata} === rq.pop_front(), "read data");
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1;
    @(posedge clk_i);
    wr(8'h00, 16'h41AB);
    wr(8'h00, 16'h44CD);
    pr(5, 16'hABCD);
    wr(8'h00, 16'h3085);
    rd(8'h0C, 16'h0031);
    pr(1, 16'h579A);
    wr(8'h00, 16'h2929);
    rd(8'h0C, 16'h0011);
    pr(8, 16'h0011);
    wr(8'h00, 16'h2969);
    wr(8'h00, 16'h1B05);
    rd(8'h18, 16'h0003);
    pr(2, 16'h0367);
    wr(8'h00, 16'h3412);
    pr(6, 16'h000B);
    pr(7, 16'h9371);
    wr(8'h00, 16'h1982);
    pr(3, 16'h579A);
    rd(8'h0C, 16'h0009);
    wr(8'h00, 16'h4802);
    wr(8'h00, 16'h4C01);
    pr(2, 16'h6700);
    pr(1, 16'h0057);
    $display("ALU test done");
    j1 = rnd();
    j2 = rnd();
    wr(8'h20, j1);
    wr(8'h24, j2);
    wr(8'h10, j1);
    wr(8'h14, j2);
    wr(8'h28, j1 ^ j2);
    pr(9'h10A, j1);
    rd(8'h1C, j2);
    pr(9'h00B, j2);
    rd(8'h1C, j1);
    pr(9, j1 ^ j2);
    pr(21, j1);
    pr(22, j2);
    wr(8'h00, 16'h5000);
    rd(8'h10, 16'h0000);
    rd(8'h14, 16'h0000);
    rd(8'h18, 16'h0000);
    for (int c = 12; c < 32; c++) if (c != 21 && c != 22) pr(9'(c), xv(5'(c)));
    bus(1, 8'h3C, {2'h2, 32'h0000_0000});
    bus(0, 8'h3C, {2'h2, 32'h0000_0000});
    $display("Register test done");
    final_report();
  end
endmodule
bind mcod_top mcod_checker chk (.*);
